// [hdl/tpli_top.sv]
// Link integrity, polarity, port select and collision logic with AHB-Lite registers
//
// How it works
// - Idle line: one-bit-wide link pulse every 16 ms
// - Pulse timer restarts at each transmit end-of-frame
// - No received pulses: transmitter held off unless disabled
// - Link-loss timer restarts on packet or pulse
// - Loss blocks packets, link pulses keep going unless auto mode switches to AUI
// - Packet or two well-spaced pulses restore link
// - Link good flag shows link state
// - Indicator pin low good, high bad, when enabled
// - Link test disable ignores link state everywhere except auto port selection
// - Polarity correct flag clear when pair reversed
// - Inhibit bit stops automatic polarity correction
// - Reversal needs inverted pulse plus four negative frames
// - Half duplex: simultaneous rx and tx is collision
// - Carrier absent or lost during AUI transmit flagged
// - AUI collision input drives MAC collision
// - Low squelch bit lowers receive threshold
// - AUI select bit routes to attachment-unit port
// - Auto mode prefers twisted pair while active
//
// Local design decisions: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "tpli_defines.svh"

module tpli_top
  import tpli_pkg::*;
#(
  parameter int unsigned LP_PERIOD_CYC = `TPLI_LP_PERIOD_MS * `TPLI_CLK_KHZ,
  parameter int unsigned LOSS_CYC = `TPLI_LOSS_MS * `TPLI_CLK_KHZ,
  parameter int unsigned GAP_MIN_CYC = `TPLI_GAP_MIN_MS * `TPLI_CLK_KHZ,
  parameter int unsigned GAP_MAX_CYC = `TPLI_GAP_MAX_MS * `TPLI_CLK_KHZ
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // AHB-Lite slave
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // MAC side, same clock
  input wire logic MAC_TX_EN_I,
  input wire logic MAC_TX_EOF_I,
  output logic MAC_COL_O,
  output logic MAC_RX_EN_O,
  // Line front ends, asynchronous
  input wire tpli_rx_t LINE_RX_I,
  output logic TP_TX_EN_O,
  output logic TP_LINK_PULSE_O,
  output logic AUI_TX_EN_O,
  output logic PORT_AUI_O,
  output logic POL_INVERT_O,
  output logic LOW_SQUELCH_O,
  output logic LINK_LED_O
);

  localparam int unsigned LPW_CYC = `TPLI_LP_WIDTH_CYC;

  // Two-stage synchroniser; stage one is read by stage two only
  tpli_rx_t rx_meta_r, rx_r, rx_d_r;
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      rx_meta_r <= '0;
      rx_r <= '0;
      rx_d_r <= '0;
    end else begin
      rx_meta_r <= LINE_RX_I;
      rx_r <= rx_meta_r;
      rx_d_r <= rx_r;
    end
  end

  logic pos_pulse, neg_pulse, any_pulse, pkt_start, eof_pos, eof_neg;
  assign pos_pulse = rx_r.pulse_pos & ~rx_d_r.pulse_pos;
  assign neg_pulse = rx_r.pulse_neg & ~rx_d_r.pulse_neg;
  assign any_pulse = pos_pulse | neg_pulse;
  assign pkt_start = rx_r.tp_active & ~rx_d_r.tp_active;
  assign eof_pos = rx_r.eof_pos & ~rx_d_r.eof_pos;
  assign eof_neg = rx_r.eof_neg & ~rx_d_r.eof_neg;

  // Control registers
  logic [15:0] line_ctl_r, self_ctl_r, test_ctl_r;
  logic carrier_loss_r;
  logic aui_sel, auto_port, pol_inhibit, led_output_control, link_test_disable, full_duplex_select;
  assign aui_sel = line_ctl_r[`TPLI_BIT_AUI_SEL];
  assign auto_port = line_ctl_r[`TPLI_BIT_AUTO_PORT];
  assign pol_inhibit = line_ctl_r[`TPLI_BIT_POL_INHIBIT];
  assign led_output_control = self_ctl_r[`TPLI_BIT_LED_CTL];
  assign link_test_disable = test_ctl_r[`TPLI_BIT_LT_DISABLE];
  assign full_duplex_select = test_ctl_r[`TPLI_BIT_FDX];

  // Link integrity state
  tpli_link_t link_r;
  logic [23:0] loss_cnt_r;
  logic [23:0] gap_cnt_r;
  logic link_good;
  assign link_good = (link_r == LINK_GOOD);

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      link_r <= LINK_FAIL;
      loss_cnt_r <= '0;
      gap_cnt_r <= '0;
    end else begin
      case (link_r)
        LINK_GOOD: begin
          if (any_pulse || pkt_start) begin
            loss_cnt_r <= '0;
          end else if (loss_cnt_r == 24'(LOSS_CYC - 1)) begin
            link_r <= LINK_FAIL;
          end else begin
            loss_cnt_r <= loss_cnt_r + 24'h000001;
          end
        end
        LINK_FAIL: begin
          loss_cnt_r <= '0;
          gap_cnt_r <= '0;
          if (pkt_start) begin
            link_r <= LINK_GOOD;
          end else if (any_pulse) begin
            link_r <= LINK_WAIT2;
          end
        end
        LINK_WAIT2: begin
          if (pkt_start) begin
            link_r <= LINK_GOOD;
          end else if (any_pulse) begin
            gap_cnt_r <= '0;
            if (gap_cnt_r >= 24'(GAP_MIN_CYC)) begin
              link_r <= LINK_GOOD;
            end
          end else if (gap_cnt_r == 24'(GAP_MAX_CYC - 1)) begin
            link_r <= LINK_FAIL;
          end else begin
            gap_cnt_r <= gap_cnt_r + 24'h000001;
          end
        end
        default: link_r <= LINK_FAIL;
      endcase
    end
  end

  // Port selection
  logic port_aui;
  assign port_aui = aui_sel | (auto_port & ~link_good);

  // Link pulse generator; period counter runs regardless of link state, pulses only while the twisted-pair port is selected
  logic [20:0] lp_cnt_r;
  logic [3:0] lpw_cnt_r;
  logic lp_out_r;
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      lp_cnt_r <= '0;
      lpw_cnt_r <= '0;
      lp_out_r <= 1'b0;
    end else if (MAC_TX_EOF_I || TP_TX_EN_O) begin
      lp_cnt_r <= '0;
      lp_out_r <= 1'b0;
    end else if (lp_cnt_r == 21'(LP_PERIOD_CYC - 1)) begin
      lp_cnt_r <= '0;
      lpw_cnt_r <= '0;
      lp_out_r <= ~port_aui;
    end else begin
      // Period counter runs under the pulse so rises stay one period apart
      lp_cnt_r <= lp_cnt_r + 21'h000001;
      if (lp_out_r && lpw_cnt_r == 4'(LPW_CYC - 1)) begin
        lp_out_r <= 1'b0;
      end else if (lp_out_r) begin
        lpw_cnt_r <= lpw_cnt_r + 4'h1;
      end
    end
  end

  // Polarity detection
  logic inv_seen_r, reversed_r;
  logic [2:0] neg_frames_r;
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      inv_seen_r <= 1'b0;
      reversed_r <= 1'b0;
      neg_frames_r <= '0;
    end else begin
      if (neg_pulse) begin
        inv_seen_r <= 1'b1;
      end else if (pos_pulse) begin
        inv_seen_r <= 1'b0;
      end
      if (eof_pos) begin
        neg_frames_r <= '0;
        reversed_r <= 1'b0;
      end else begin
        if (eof_neg && neg_frames_r != `TPLI_NEG_FRAMES) begin
          neg_frames_r <= neg_frames_r + 3'h1;
        end
        if (inv_seen_r && neg_frames_r == `TPLI_NEG_FRAMES) begin
          reversed_r <= 1'b1;
        end
      end
    end
  end

  // Carrier loss on the attachment-unit port; set beats a clear
  logic crs_seen_r, tx_d_r, evt_clr;
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      crs_seen_r <= 1'b0;
      tx_d_r <= 1'b0;
      carrier_loss_r <= 1'b0;
    end else begin
      tx_d_r <= MAC_TX_EN_I;
      if (MAC_TX_EN_I && !tx_d_r) begin
        crs_seen_r <= 1'b0;
      end else if (MAC_TX_EN_I && rx_r.aui_crs) begin
        crs_seen_r <= 1'b1;
      end
      if (port_aui && MAC_TX_EN_I && crs_seen_r && !rx_r.aui_crs) begin
        carrier_loss_r <= 1'b1;
      end else if (port_aui && !MAC_TX_EN_I && tx_d_r && !crs_seen_r) begin
        carrier_loss_r <= 1'b1;
      end else if (evt_clr) begin
        carrier_loss_r <= 1'b0;
      end
    end
  end

  // Line outputs
  logic tx_allowed;
  assign tx_allowed = link_good | link_test_disable;
  // The packet that revives a bad link is dropped to its end
  logic drop_pkt_r;
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      drop_pkt_r <= 1'b0;
    end else if (pkt_start && !tx_allowed) begin
      drop_pkt_r <= 1'b1;
    end else if (!rx_r.tp_active) begin
      drop_pkt_r <= 1'b0;
    end
  end
  assign TP_TX_EN_O = MAC_TX_EN_I & ~port_aui & tx_allowed;
  assign AUI_TX_EN_O = MAC_TX_EN_I & port_aui;
  assign TP_LINK_PULSE_O = lp_out_r;
  assign PORT_AUI_O = port_aui;
  assign POL_INVERT_O = reversed_r & ~pol_inhibit;
  assign LOW_SQUELCH_O = line_ctl_r[`TPLI_BIT_LOW_SQUELCH];
  // Frames before a good link or an uncorrected reversal are dropped
  assign MAC_RX_EN_O = port_aui ? rx_r.aui_crs :
                       (rx_r.tp_active & tx_allowed & ~drop_pkt_r &
                        ~(reversed_r & pol_inhibit));
  assign MAC_COL_O = port_aui ? rx_r.aui_col :
                     (~full_duplex_select & rx_r.tp_active & TP_TX_EN_O);

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      LINK_LED_O <= 1'b1;
    end else begin
      LINK_LED_O <= led_output_control | ~tx_allowed;
    end
  end

  // AHB-Lite slave, zero wait states, read data loaded at the address phase
  logic ph_wr_r;
  logic [`TPLI_ADDR_W-1:0] ph_addr_r;
  logic addr_ok, take;
  logic [31:0] rd_mux;
  assign take = HSEL_I & HTRANS_I[1] & HREADY_I;
  assign addr_ok = (HADDR_I[31:`TPLI_ADDR_W] == '0);
  assign evt_clr = ph_wr_r && ph_addr_r == `TPLI_OFF_TX_EVENT &&
                   HWDATA_I[`TPLI_BIT_CARRIER_LOSS];

  always_comb begin
    rd_mux = 32'h00000000;
    if (addr_ok) begin
      case (HADDR_I[`TPLI_ADDR_W-1:0])
        `TPLI_OFF_LINE_CTL: rd_mux = {16'h0000, line_ctl_r};
        `TPLI_OFF_SELF_CTL: rd_mux = {16'h0000, self_ctl_r};
        `TPLI_OFF_TEST_CTL: rd_mux = {16'h0000, test_ctl_r};
        `TPLI_OFF_LINE_ST: begin
          rd_mux[`TPLI_BIT_LINK_GOOD] = tx_allowed;
          rd_mux[`TPLI_BIT_POL_CORRECT] = ~reversed_r;
          rd_mux[`TPLI_BIT_CARRIER] = port_aui ? rx_r.aui_crs : rx_r.tp_active;
          rd_mux[`TPLI_BIT_PORT_AUI] = port_aui;
        end
        `TPLI_OFF_TX_EVENT: rd_mux[`TPLI_BIT_CARRIER_LOSS] = carrier_loss_r;
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ph_wr_r <= 1'b0;
      ph_addr_r <= '0;
      HRDATA_O <= 32'h00000000;
    end else begin
      ph_wr_r <= take & HWRITE_I & addr_ok;
      if (take) begin
        ph_addr_r <= HADDR_I[`TPLI_ADDR_W-1:0];
        if (!HWRITE_I) begin
          HRDATA_O <= rd_mux;
        end
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      line_ctl_r <= `TPLI_RST_CTL;
      self_ctl_r <= `TPLI_RST_CTL;
      test_ctl_r <= `TPLI_RST_CTL;
    end else if (ph_wr_r) begin
      case (ph_addr_r)
        `TPLI_OFF_LINE_CTL: line_ctl_r <= HWDATA_I[15:0];
        `TPLI_OFF_SELF_CTL: self_ctl_r <= HWDATA_I[15:0];
        `TPLI_OFF_TEST_CTL: test_ctl_r <= HWDATA_I[15:0];
        default: ;
      endcase
    end
  end

  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;

  // Checks
  a_pulse_width: assert property (@(posedge CLK_I)
    disable iff (RST_I || MAC_TX_EOF_I || TP_TX_EN_O)
    $rose(lp_out_r) |-> lp_out_r [*8] ##1 lp_out_r [*4] ##1 !lp_out_r)
    else $error("link pulse width wrong");
  a_eof_restart: assert property (@(posedge CLK_I) disable iff (RST_I)
    MAC_TX_EOF_I |=> lp_cnt_r == '0 && !lp_out_r)
    else $error("pulse timer not restarted at end of frame");
  a_tx_gated: assert property (@(posedge CLK_I) disable iff (RST_I)
    (!link_good && !link_test_disable) |-> !TP_TX_EN_O)
    else $error("transmit enabled with bad link");
  a_loss_restart: assert property (@(posedge CLK_I) disable iff (RST_I)
    (link_good && pkt_start) |=> loss_cnt_r == '0 && link_good)
    else $error("link-loss timer not restarted");
  a_loss_expire: assert property (@(posedge CLK_I) disable iff (RST_I)
    (link_good && !any_pulse && !pkt_start && loss_cnt_r == 24'(LOSS_CYC - 1))
    |=> link_r == LINK_FAIL)
    else $error("link-loss timer did not expire");
  a_pkt_restore: assert property (@(posedge CLK_I) disable iff (RST_I)
    (link_r == LINK_FAIL && pkt_start && !link_test_disable && !port_aui)
    |=> link_good && !MAC_RX_EN_O && !$past(MAC_RX_EN_O))
    else $error("packet did not restore link or was passed");
  a_led_follow: assert property (@(posedge CLK_I) disable iff (RST_I)
    !led_output_control && $changed(tx_allowed) |=> LINK_LED_O == !$past(tx_allowed))
    else $error("link indicator wrong");
  a_pol_reverse: assert property (@(posedge CLK_I) disable iff (RST_I)
    $rose(reversed_r) |-> $past(inv_seen_r) && $past(neg_frames_r) == `TPLI_NEG_FRAMES)
    else $error("reversal declared too early");
  a_half_col: assert property (@(posedge CLK_I) disable iff (RST_I)
    (!port_aui && !full_duplex_select && TP_TX_EN_O && rx_r.tp_active) |-> MAC_COL_O)
    else $error("collision not signalled");
  a_crs_loss: assert property (@(posedge CLK_I) disable iff (RST_I)
    (port_aui && $fell(MAC_TX_EN_I) && !crs_seen_r) |=> carrier_loss_r)
    else $error("carrier loss not flagged");

endmodule

// [pkg/tpli_defines.svh]
// Register offsets, bit positions and timing figures of the link integrity block
`ifndef TPLI_DEFINES_SVH
`define TPLI_DEFINES_SVH

`define TPLI_ADDR_W 8
`define TPLI_OFF_LINE_CTL 8'h00
`define TPLI_OFF_LINE_ST 8'h04
`define TPLI_OFF_SELF_CTL 8'h08
`define TPLI_OFF_TEST_CTL 8'h0C
`define TPLI_OFF_TX_EVENT 8'h10

`define TPLI_BIT_AUI_SEL 8
`define TPLI_BIT_AUTO_PORT 9
`define TPLI_BIT_POL_INHIBIT 12
`define TPLI_BIT_LOW_SQUELCH 14
`define TPLI_BIT_LINK_GOOD 7
`define TPLI_BIT_POL_CORRECT 12
`define TPLI_BIT_CARRIER 14
`define TPLI_BIT_PORT_AUI 15
`define TPLI_BIT_LED_CTL 13
`define TPLI_BIT_LT_DISABLE 7
`define TPLI_BIT_FDX 14
`define TPLI_BIT_CARRIER_LOSS 6

`define TPLI_RST_CTL 16'h0000

`define TPLI_CLK_KHZ 125000
`define TPLI_LP_PERIOD_MS 16
`define TPLI_LOSS_MS 100
`define TPLI_GAP_MIN_MS 5
`define TPLI_GAP_MAX_MS 100
`define TPLI_LP_WIDTH_NS 100
`define TPLI_LP_WIDTH_CYC ((`TPLI_LP_WIDTH_NS * 125) / 1000)
`define TPLI_NEG_FRAMES 3'd4

`endif

// [pkg/tpli_pkg.sv]
// Types shared by the link integrity block
package tpli_pkg;
  typedef enum logic [1:0] {
    LINK_GOOD,
    LINK_FAIL,
    LINK_WAIT2
  } tpli_link_t;

  // Receive indications from the twisted-pair and attachment-unit front ends
  typedef struct packed {
    logic pulse_pos;
    logic pulse_neg;
    logic tp_active;
    logic eof_pos;
    logic eof_neg;
    logic aui_crs;
    logic aui_col;
  } tpli_rx_t;
endpackage

// [tb/tpli_far_end.sv]
// Remote station and AUI transceiver model driving the line indications
`timescale 1ns/1ps
module tpli_far_end
  import tpli_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Device transmit side
  input wire logic aui_tx_en_i,
  // Line indications
  output tpli_rx_t rx_o
);
  logic drop_crs = 1'b0;
  logic col_on = 1'b0;

  initial rx_o = '0;

  // Echo of AUI transmit; drop_crs models a transceiver that loses the loop-back
  always @(posedge clk_i) begin
    rx_o.aui_crs <= aui_tx_en_i & ~drop_crs;
    rx_o.aui_col <= col_on;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic pulse(input bit neg);
    if (neg) begin
      rx_o.pulse_neg <= 1'b1;
    end else begin
      rx_o.pulse_pos <= 1'b1;
    end
    hold(3);
    rx_o.pulse_pos <= 1'b0;
    rx_o.pulse_neg <= 1'b0;
    hold(3);
  endtask

  // Packet body, then end-of-frame of the given polarity
  task automatic frame(input bit neg);
    rx_o.tp_active <= 1'b1;
    hold(20);
    rx_o.tp_active <= 1'b0;
    if (neg) begin
      rx_o.eof_neg <= 1'b1;
    end else begin
      rx_o.eof_pos <= 1'b1;
    end
    hold(3);
    rx_o.eof_pos <= 1'b0;
    rx_o.eof_neg <= 1'b0;
    hold(3);
  endtask
endmodule

// [tb/tpli_top_tb.sv]
// Self-checking bench for the link integrity block
`timescale 1ns/1ps
module tpli_top_tb
  import tpli_pkg::*;
;
  localparam int LP = 200;
  logic CLK_I = 1'b0;
  logic RST_I = 1'b1;
  logic [31:0] HADDR_I = '0;
  logic [31:0] HWDATA_I = '0;
  logic [31:0] HRDATA_O;
  logic [1:0] HTRANS_I = '0;
  logic HWRITE_I = 1'b0;
  logic HSEL_I = 1'b0;
  logic [2:0] HSIZE_I = 3'h0;
  logic HREADYOUT_O, HRESP_O, MAC_COL_O, MAC_RX_EN_O, TP_TX_EN_O, TP_LINK_PULSE_O;
  logic MAC_TX_EN_I = 1'b0;
  logic MAC_TX_EOF_I = 1'b0;
  logic AUI_TX_EN_O, PORT_AUI_O, POL_INVERT_O, LOW_SQUELCH_O, LINK_LED_O;
  logic rx_seen = 1'b0;
  tpli_rx_t LINE_RX_I;
  int errors = 0;
  int checks = 0;
  logic [31:0] d;

  tpli_top #(.LP_PERIOD_CYC(LP), .LOSS_CYC(2000), .GAP_MIN_CYC(50), .GAP_MAX_CYC(1000)) i_dut (
    .CLK_I(CLK_I), .RST_I(RST_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I),
    .HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I), .HWDATA_I(HWDATA_I), .HREADY_I(HREADYOUT_O),
    .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
    .MAC_TX_EN_I(MAC_TX_EN_I), .MAC_TX_EOF_I(MAC_TX_EOF_I), .MAC_COL_O(MAC_COL_O),
    .MAC_RX_EN_O(MAC_RX_EN_O), .LINE_RX_I(LINE_RX_I), .TP_TX_EN_O(TP_TX_EN_O),
    .TP_LINK_PULSE_O(TP_LINK_PULSE_O), .AUI_TX_EN_O(AUI_TX_EN_O), .PORT_AUI_O(PORT_AUI_O),
    .POL_INVERT_O(POL_INVERT_O), .LOW_SQUELCH_O(LOW_SQUELCH_O), .LINK_LED_O(LINK_LED_O));

  tpli_far_end i_far (.clk_i(CLK_I), .aui_tx_en_i(AUI_TX_EN_O), .rx_o(LINE_RX_I));

  initial begin
    forever #4 CLK_I = ~CLK_I;
  end

  // Remembers any accepted receive data since last cleared
  always @(posedge CLK_I) begin
    if (MAC_RX_EN_O === 1'b1) rx_seen <= 1'b1;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_I);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    HSEL_I <= 1'b1;
    HSIZE_I <= 3'h2;
    HADDR_I <= {24'h0, a};
    HWRITE_I <= w;
    HTRANS_I <= 2'h2;
    do cyc(1); while (HREADYOUT_O !== 1'b1);
    HTRANS_I <= 2'h0;
    HSEL_I <= 1'b0;
    HWDATA_I <= wd;
    do cyc(1); while (HREADYOUT_O !== 1'b1);
    d = HRDATA_O;
    chk(HRESP_O, 1'b0);
  endtask

  task automatic rbit(input logic [7:0] a, input int b, input logic e);
    ahb(a, 1'b0, '0);
    chk(d[b], e);
  endtask

  task automatic tx(input int n);
    MAC_TX_EN_I <= 1'b1;
    cyc(n);
    MAC_TX_EN_I <= 1'b0;
    MAC_TX_EOF_I <= 1'b1;
    cyc(1);
    MAC_TX_EOF_I <= 1'b0;
  endtask

  task automatic rise(output int n);
    n = 0;
    while (TP_LINK_PULSE_O !== 1'b0) cyc(1);
    while (TP_LINK_PULSE_O !== 1'b1 && n < 1000) begin
      cyc(1);
      n++;
    end
  endtask

  task automatic t_reset;
    chk(LINK_LED_O, 1'b1);
    rbit(8'h04, 7, 1'b0);
    ahb(8'h80, 1'b1, 32'hFFFF);
    rbit(8'h80, 0, 1'b0);
    MAC_TX_EN_I <= 1'b1;
    cyc(3);
    chk(TP_TX_EN_O, 1'b0);
    MAC_TX_EN_I <= 1'b0;
  endtask

  task automatic t_pulse;
    int w;
    int n;
    rise(n);
    w = 0;
    while (TP_LINK_PULSE_O === 1'b1) begin
      cyc(1);
      w++;
    end
    chk(w, 12);
    rise(n);
    chk(w + n inside {[LP - 2:LP + 2]}, 1'b1);
    cyc(100);
    tx(50);
    rise(n);
    chk(n inside {[LP - 5:LP + 5]}, 1'b1);
  endtask

  // Too-close pair first, then a valid gap
  task automatic t_link;
    i_far.pulse(1'b0);
    cyc(14);
    i_far.pulse(1'b0);
    cyc(4);
    rbit(8'h04, 7, 1'b0);
    cyc(100);
    i_far.pulse(1'b0);
    cyc(4);
    rbit(8'h04, 7, 1'b1);
    chk(LINK_LED_O, 1'b0);
    ahb(8'h08, 1'b1, 32'h2000);
    cyc(2);
    chk(LINK_LED_O, 1'b1);
    ahb(8'h08, 1'b1, 32'h0);
    MAC_TX_EN_I <= 1'b1;
    i_far.rx_o.tp_active <= 1'b1;
    cyc(4);
    chk(TP_TX_EN_O, 1'b1);
    chk(MAC_COL_O, 1'b1);
    ahb(8'h0C, 1'b1, 32'h4000);
    cyc(1);
    chk(MAC_COL_O, 1'b0);
    ahb(8'h0C, 1'b1, 32'h0);
    MAC_TX_EN_I <= 1'b0;
    i_far.rx_o.tp_active <= 1'b0;
    cyc(4);
  endtask

  task automatic t_pol;
    i_far.pulse(1'b1);
    repeat (3) i_far.frame(1'b1);
    rbit(8'h04, 12, 1'b1);
    i_far.frame(1'b1);
    cyc(4);
    rbit(8'h04, 12, 1'b0);
    chk(POL_INVERT_O, 1'b1);
    ahb(8'h00, 1'b1, 32'h1000);
    cyc(1);
    chk(POL_INVERT_O, 1'b0);
    rbit(8'h04, 12, 1'b0);
    ahb(8'h00, 1'b1, 32'h0);
    i_far.frame(1'b0);
    cyc(4);
    rbit(8'h04, 12, 1'b1);
  endtask

  task automatic t_loss;
    int n;
    repeat (2) begin
      cyc(1500);
      i_far.pulse(1'b0);
    end
    rbit(8'h04, 7, 1'b1);
    cyc(2100);
    rbit(8'h04, 7, 1'b0);
    rise(n);
    chk(n < LP + 5, 1'b1);
    MAC_TX_EN_I <= 1'b1;
    cyc(3);
    chk(TP_TX_EN_O, 1'b0);
    ahb(8'h0C, 1'b1, 32'h80);
    cyc(1);
    chk(TP_TX_EN_O, 1'b1);
    ahb(8'h0C, 1'b1, 32'h0);
    MAC_TX_EN_I <= 1'b0;
    rx_seen <= 1'b0;
    i_far.frame(1'b0);
    cyc(4);
    chk(rx_seen, 1'b0);
    rbit(8'h04, 7, 1'b1);
    i_far.frame(1'b0);
    cyc(4);
    chk(rx_seen, 1'b1);
  endtask

  task automatic t_aui;
    ahb(8'h00, 1'b1, 32'h4100);
    cyc(1);
    chk(PORT_AUI_O, 1'b1);
    chk(LOW_SQUELCH_O, 1'b1);
    tx(30);
    cyc(4);
    rbit(8'h10, 6, 1'b0);
    i_far.drop_crs <= 1'b1;
    MAC_TX_EN_I <= 1'b1;
    cyc(4);
    chk(AUI_TX_EN_O, 1'b1);
    tx(20);
    cyc(4);
    rbit(8'h10, 6, 1'b1);
    ahb(8'h10, 1'b1, 32'h40);
    cyc(1);
    rbit(8'h10, 6, 1'b0);
    i_far.drop_crs <= 1'b0;
    i_far.col_on <= 1'b1;
    cyc(4);
    chk(MAC_COL_O, 1'b1);
    i_far.col_on <= 1'b0;
    ahb(8'h00, 1'b1, 32'h0);
    cyc(1);
    chk(LOW_SQUELCH_O, 1'b0);
  endtask

  task automatic t_auto;
    ahb(8'h00, 1'b1, 32'h200);
    cyc(1);
    chk(PORT_AUI_O, 1'b0);
    cyc(2100);
    chk(PORT_AUI_O, 1'b1);
    i_far.frame(1'b0);
    cyc(4);
    chk(PORT_AUI_O, 1'b0);
  endtask

  task automatic conclude;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    cyc(5);
    RST_I <= 1'b0;
    cyc(1);
    t_reset();
    t_pulse();
    t_link();
    t_pol();
    t_loss();
    t_aui();
    t_auto();
    conclude();
  end

  // Whole run is about 10000 cycles
  initial begin
    cyc(30000);
    errors++;
    conclude();
  end
endmodule
